// *** src/esm_pkg.sv ***
// Notes on behaviour
// - message taken from overhead byte bits 6-8
// - message is a four-bit quality code
// - index bits 6,7 place bit 8 MSB-first
// - works only in E3 path-overhead mode
// - extraction only while receive enable set
// - latest message readable in bits 3:0
// - field overwritten by every assembled message
// - change and out-of-sequence interrupts, separately enabled
// - change interrupt when new message differs
// - top enable bit 2 gates all interrupts
// - receive framer enable bit 7 gates second
// - source enables bit 6 change, bit 5 sequence
// - receive framer status bit 7 set on an event whose source enable is set
package esm_pkg;
    localparam int AW = 16;
    localparam int DW = 8;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [15:0] ADR_OP_INT_EN = 16'h0116;
    localparam logic [15:0] ADR_FRM_MODE = 16'h1100;
    localparam logic [15:0] ADR_FRM_INT_EN = 16'h1104;
    localparam logic [15:0] ADR_FRM_INT_ST = 16'h1105;
    localparam logic [15:0] ADR_RX_INT_EN = 16'h1112;
    localparam logic [15:0] ADR_RX_INT_ST = 16'h1113;
    localparam logic [15:0] ADR_SYNC_MSG = 16'h112C;
    // ****************************************
    // field positions
    // ****************************************
    localparam int OP_FRM_EN_BIT = 2;
    localparam int MODE_RATE_BIT = 6;
    localparam int MODE_FMT_BIT = 2;
    localparam int FRM_RX_BIT = 7;
    localparam int SRC_CHG_BIT = 6;
    localparam int SRC_OOS_BIT = 5;
    localparam int MSG_EN_BIT = 7;
    // overhead byte, bit 1 is the msb (byte bit 7)
    localparam int OH_IDX_HI = 2;
    localparam int OH_IDX_LO = 1;
    localparam int OH_DATA = 0;
    // ****************************************
    // reset values, write masks and index sequence
    // ****************************************
    localparam logic [7:0] RST_OP_INT_EN = 8'h00;
    localparam logic [7:0] RST_FRM_MODE = 8'h00;
    localparam logic [7:0] RST_FRM_INT_EN = 8'h00;
    localparam logic [7:0] RST_RX_INT_EN = 8'h00;
    localparam logic [7:0] OP_INT_EN_WMASK = 8'h0C;
    localparam logic [7:0] FRM_INT_EN_WMASK = 8'h80;
    localparam logic [7:0] RX_INT_EN_WMASK = 8'h7F;
    localparam logic [1:0] IDX_FIRST = 2'h0;
    localparam logic [1:0] IDX_STEP = 2'h1;
endpackage

// *** src/esm_assembler.sv ***
`timescale 1ns/10ps
module esm_assembler (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    input wire logic oh_valid,
    input wire logic [7:0] oh_byte,
    output logic [3:0] msg,
    output logic [1:0] idx,
    output logic msg_new,
    output logic chg_evt,
    output logic oos_evt
);
    logic [3:0] shadow_ff, nxt_shadow;
    logic [3:0] msg_ff, nxt_msg;
    logic [1:0] idx_ff, nxt_idx;
    logic seen_ff, nxt_seen;
    logic new_ff, nxt_new, chg_ff, nxt_chg, oos_ff, nxt_oos;
    logic [1:0] in_idx;

    assign in_idx = oh_byte[esm_pkg::OH_IDX_HI:esm_pkg::OH_IDX_LO];

    always_comb begin
        nxt_shadow = shadow_ff;
        nxt_msg = msg_ff;
        nxt_idx = idx_ff;
        nxt_seen = seen_ff;
        nxt_new = 1'b0;
        nxt_chg = 1'b0;
        nxt_oos = 1'b0;
        if (!run) begin
            nxt_seen = 1'b0;
        end else if (oh_valid) begin
            // index 00 is message bit 1, the msb
            nxt_shadow[2'd3 - in_idx] = oh_byte[esm_pkg::OH_DATA];
            nxt_idx = in_idx;
            nxt_seen = 1'b1;
            if (seen_ff && in_idx != idx_ff + esm_pkg::IDX_STEP) begin
                nxt_oos = 1'b1;
            end
            if (in_idx == 2'd3) begin
                // four-bit code complete after its lsb
                nxt_msg = {nxt_shadow[3:1], oh_byte[esm_pkg::OH_DATA]};
                nxt_new = 1'b1;
                nxt_chg = (nxt_msg != msg_ff);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shadow_ff <= 4'h0;
            msg_ff <= 4'h0;
            idx_ff <= 2'h0;
            seen_ff <= 1'b0;
            new_ff <= 1'b0;
            chg_ff <= 1'b0;
            oos_ff <= 1'b0;
        end else begin
            shadow_ff <= nxt_shadow;
            msg_ff <= nxt_msg;
            idx_ff <= nxt_idx;
            seen_ff <= nxt_seen;
            new_ff <= nxt_new;
            chg_ff <= nxt_chg;
            oos_ff <= nxt_oos;
        end
    end

    assign msg = msg_ff;
    assign idx = idx_ff;
    assign msg_new = new_ff;
    assign chg_evt = chg_ff;
    assign oos_evt = oos_ff;
endmodule

// *** src/esm_top.sv ***
`timescale 1ns/10ps
module esm_top (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic oh_valid,
    input wire logic [7:0] oh_byte,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_sel_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_s1_ff, rst_ff;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_ff <= 1'b0;
            rst_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_ff <= rst_s1_ff;
        end
    end

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] op_en_ff, nxt_op_en;
    logic [7:0] mode_ff, nxt_mode;
    logic [7:0] frm_en_ff, nxt_frm_en;
    logic [7:0] src_en_ff, nxt_src_en;
    logic msg_en_ff, nxt_msg_en;
    logic st_chg_ff, nxt_st_chg, st_oos_ff, nxt_st_oos;
    logic ack_ff, nxt_ack;
    logic [7:0] rdat_ff, nxt_rdat;
    logic irq_ff, nxt_irq;
    logic run;
    logic [3:0] msg;
    logic [1:0] idx;
    logic chg_evt, oos_evt;
    logic req, wr;
    logic [7:0] rd_mux;
    logic frm_st;

    function automatic logic [7:0] upd(input logic [7:0] cur,
                                       input logic [7:0] d,
                                       input logic [7:0] m);
        upd = (cur & ~m) | (d & m);
    endfunction

    // e3 and path-overhead format only
    assign run = !mode_ff[esm_pkg::MODE_RATE_BIT]
        && mode_ff[esm_pkg::MODE_FMT_BIT] && msg_en_ff;

    esm_assembler u_asm (
        .clk_sys(clk_sys),
        .rst_n(rst_ff),
        .run(run),
        .oh_valid(oh_valid),
        .oh_byte(oh_byte),
        .msg(msg),
        .idx(idx),
        .msg_new(),
        .chg_evt(chg_evt),
        .oos_evt(oos_evt)
    );

    // sticky status gated by source enable; rx framer status follows it
    assign frm_st = (st_chg_ff && src_en_ff[esm_pkg::SRC_CHG_BIT])
        || (st_oos_ff && src_en_ff[esm_pkg::SRC_OOS_BIT]);

    assign req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr = req && wb_we_i && wb_sel_i;

    always_comb begin
        rd_mux = 8'h00;
        unique case (wb_adr_i)
            esm_pkg::ADR_OP_INT_EN: rd_mux = op_en_ff;
            esm_pkg::ADR_FRM_MODE: rd_mux = mode_ff;
            esm_pkg::ADR_FRM_INT_EN: rd_mux = frm_en_ff;
            esm_pkg::ADR_FRM_INT_ST: rd_mux = {frm_st, 7'h00};
            esm_pkg::ADR_RX_INT_EN: rd_mux = src_en_ff;
            esm_pkg::ADR_RX_INT_ST: rd_mux = {1'b0, st_chg_ff, st_oos_ff, 5'h00};
            esm_pkg::ADR_SYNC_MSG: rd_mux = {msg_en_ff, idx, 1'b0, msg};
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        nxt_op_en = op_en_ff;
        nxt_mode = mode_ff;
        nxt_frm_en = frm_en_ff;
        nxt_src_en = src_en_ff;
        nxt_msg_en = msg_en_ff;
        nxt_st_chg = st_chg_ff;
        nxt_st_oos = st_oos_ff;
        nxt_ack = req;
        nxt_rdat = req ? rd_mux : rdat_ff;
        if (wr) begin
            unique case (wb_adr_i)
                esm_pkg::ADR_OP_INT_EN:
                    nxt_op_en = upd(op_en_ff, wb_dat_i, esm_pkg::OP_INT_EN_WMASK);
                esm_pkg::ADR_FRM_MODE: nxt_mode = wb_dat_i;
                esm_pkg::ADR_FRM_INT_EN:
                    nxt_frm_en = upd(frm_en_ff, wb_dat_i, esm_pkg::FRM_INT_EN_WMASK);
                esm_pkg::ADR_RX_INT_EN:
                    nxt_src_en = upd(src_en_ff, wb_dat_i, esm_pkg::RX_INT_EN_WMASK);
                esm_pkg::ADR_RX_INT_ST: begin
                    // write one to clear
                    if (wb_dat_i[esm_pkg::SRC_CHG_BIT]) nxt_st_chg = 1'b0;
                    if (wb_dat_i[esm_pkg::SRC_OOS_BIT]) nxt_st_oos = 1'b0;
                end
                esm_pkg::ADR_SYNC_MSG: nxt_msg_en = wb_dat_i[esm_pkg::MSG_EN_BIT];
                default: nxt_ack = req;
            endcase
        end
        // a new event wins over a same-cycle clear
        if (chg_evt) nxt_st_chg = 1'b1;
        if (oos_evt) nxt_st_oos = 1'b1;
        nxt_irq = op_en_ff[esm_pkg::OP_FRM_EN_BIT]
            && frm_en_ff[esm_pkg::FRM_RX_BIT]
            && ((st_chg_ff && src_en_ff[esm_pkg::SRC_CHG_BIT])
            || (st_oos_ff && src_en_ff[esm_pkg::SRC_OOS_BIT]));
    end

    always_ff @(posedge clk_sys or negedge rst_ff) begin
        if (!rst_ff) begin
            op_en_ff <= esm_pkg::RST_OP_INT_EN;
            mode_ff <= esm_pkg::RST_FRM_MODE;
            frm_en_ff <= esm_pkg::RST_FRM_INT_EN;
            src_en_ff <= esm_pkg::RST_RX_INT_EN;
            msg_en_ff <= 1'b0;
            st_chg_ff <= 1'b0;
            st_oos_ff <= 1'b0;
            ack_ff <= 1'b0;
            rdat_ff <= 8'h00;
            irq_ff <= 1'b0;
        end else begin
            op_en_ff <= nxt_op_en;
            mode_ff <= nxt_mode;
            frm_en_ff <= nxt_frm_en;
            src_en_ff <= nxt_src_en;
            msg_en_ff <= nxt_msg_en;
            st_chg_ff <= nxt_st_chg;
            st_oos_ff <= nxt_st_oos;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
            irq_ff <= nxt_irq;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign irq = irq_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_ff);

    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
    AST_IRQ_TOP: assert property (
        !op_en_ff[esm_pkg::OP_FRM_EN_BIT] |=> !irq)
        else $error("irq without top enable");
    AST_IRQ_RX: assert property (
        !frm_en_ff[esm_pkg::FRM_RX_BIT] |=> !irq)
        else $error("irq without framer enable");
    AST_CHG_STICKY: assert property (chg_evt |=> st_chg_ff)
        else $error("change event lost");
    AST_OOS_STICKY: assert property (oos_evt |=> st_oos_ff)
        else $error("sequence event lost");
    AST_NO_RUN: assert property (!run |=> !chg_evt && !oos_evt)
        else $error("event while disabled");
    AST_IRQ_SRC: assert property (irq |-> $past(frm_st))
        else $error("irq without source");
    AST_MSG_HOLD: assert property (!run |=> $stable(msg))
        else $error("message changed while disabled");
    CV_CHG: cover property (chg_evt);
    CV_OOS: cover property (oos_evt);
    CV_IRQ: cover property (irq);
endmodule

// *** dv/esm_far_end.sv ***
`timescale 1ns/10ps
// ****************************************
// far-end terminal: one overhead byte per frame
// ****************************************
module esm_far_end (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic [3:0] msg,
    input wire logic skip,
    output logic oh_valid,
    output logic [7:0] oh_byte
);
    logic [1:0] idx;
    logic [1:0] gap;
    initial begin
        oh_valid = 1'b0;
        oh_byte = 8'h00;
        idx = 2'h0;
        gap = 2'h0;
    end
    always @(posedge clk_sys) begin
        gap <= run ? gap + 2'h1 : 2'h0;
        oh_valid <= run && gap == 2'h3;
        if (!run) begin
            idx <= 2'h0;
        end
        if (run && gap == 2'h3) begin
            oh_byte <= {5'h15, idx, msg[~idx]};
            // skip makes the index jump, for the out-of-sequence case
            idx <= idx + 2'h1 + {1'b0, skip};
        end else begin
            // not a frame byte: never leave the last value standing
            oh_byte <= ~oh_byte;
        end
    end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    logic clk_sys, arst_n, oh_valid, irq, run, skip, cyc, stb, we, ack;
    logic sel, wsel;
    logic [15:0] adr;
    logic [7:0] oh_byte, dat_w, dat_r, rd;
    logic [3:0] msg;
    int num_errors = 0;
    int comparisons = 0;
    logic [15:0] gate_adr [3] = '{16'h0116, 16'h1104, 16'h1112};
    logic [7:0] gate_on [3] = '{8'h04, 8'h80, 8'h60};
    esm_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .oh_valid(oh_valid),
        .oh_byte(oh_byte), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_sel_i(sel),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .irq(irq));
    esm_far_end far (.clk_sys(clk_sys), .run(run), .msg(msg),
        .skip(skip), .oh_valid(oh_valid), .oh_byte(oh_byte));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ****************************************
    // bus and check tasks
    // ****************************************
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clk_sys);
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask
    // eight frames, so without skip the last frame carries index 3
    task automatic frames(input logic [3:0] m, input logic s);
        msg <= m;
        skip <= s;
        run <= 1'b1;
        repeat (32) @(posedge clk_sys);
        run <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        {arst_n, run, skip, cyc, stb, we, sel} = 7'h00;
        wsel = 1'b1;
        {msg, adr, dat_w} = 28'h0;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_chk(16'h112C, 8'h00);
        rd_chk(16'h1100, 8'h00);
        foreach (gate_adr[i]) rd_chk(gate_adr[i], 8'h00);
        wr(16'h1234, 8'hFF);
        rd_chk(16'h1234, 8'h00);
        // a write with its byte lane off must not land
        wsel = 1'b0;
        wr(16'h1100, 8'hFF);
        wsel = 1'b1;
        rd_chk(16'h1100, 8'h00);
        wr(16'h112C, 8'hFF);
        frames(4'hA, 1'b0);
        rd_chk(16'h112C, 8'h80);
        foreach (gate_adr[i]) wr(gate_adr[i], gate_on[i]);
        wr(16'h1100, 8'h04);
        frames(4'hA, 1'b0);
        rd_chk(16'h112C, 8'hEA);
        rd_chk(16'h1113, 8'h40);
        rd_chk(16'h1105, 8'h80);
        irq_chk(1'b1);
        foreach (gate_adr[i]) begin
            wr(gate_adr[i], 8'h00);
            irq_chk(1'b0);
            wr(gate_adr[i], gate_on[i]);
            irq_chk(1'b1);
        end
        wr(16'h1113, 8'h40);
        irq_chk(1'b0);
        frames(4'hA, 1'b0);
        rd_chk(16'h1113, 8'h00);
        frames(4'h5, 1'b0);
        rd_chk(16'h112C, 8'hE5);
        wr(16'h1113, 8'h40);
        frames(4'h5, 1'b1);
        rd_chk(16'h1113, 8'h20);
        rd_chk(16'h112C, 8'hC5);
        irq_chk(1'b1);
        wr(16'h1113, 8'h20);
        wr(16'h112C, 8'h00);
        frames(4'h3, 1'b0);
        rd_chk(16'h112C, 8'h45);
        rd_chk(16'h1113, 8'h00);
        // a reset after the last frames clears the enables and the held message
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_chk(16'h112C, 8'h00);
        rd_chk(16'h1112, 8'h00);
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end
endmodule
